/* File: hw/rscp_pkg.sv */
`default_nettype none
package rscp_pkg;

  localparam int          WORD_BITS      = 24;
  localparam int          CMD_LSB        = 20;
  localparam int          ADDR_LSB       = 16;
  localparam int          WIPER_BITS     = 10;
  localparam int          NV_BITS        = 16;
  localparam int          NV_DEPTH       = 16;

  localparam logic [3:0]  CMD_NOP        = 4'h0;
  localparam logic [3:0]  CMD_NV_TO_WIPER = 4'h1;
  localparam logic [3:0]  CMD_SAVE_WIPER = 4'h2;
  localparam logic [3:0]  CMD_WRITE_NV   = 4'h3;
  localparam logic [3:0]  CMD_RSHIFT     = 4'h4;
  localparam logic [3:0]  CMD_RSHIFT_ALL = 4'h5;
  localparam logic [3:0]  CMD_DEC        = 4'h6;
  localparam logic [3:0]  CMD_DEC_ALL    = 4'h7;
  localparam logic [3:0]  CMD_RELOAD_ALL = 4'h8;
  localparam logic [3:0]  CMD_READ_NV    = 4'h9;
  localparam logic [3:0]  CMD_READ_WIPER = 4'ha;
  localparam logic [3:0]  CMD_WRITE_WIPER = 4'hb;
  localparam logic [3:0]  CMD_LSHIFT     = 4'hc;
  localparam logic [3:0]  CMD_LSHIFT_ALL = 4'hd;
  localparam logic [3:0]  CMD_INC        = 4'he;
  localparam logic [3:0]  CMD_INC_ALL    = 4'hf;

  localparam logic [3:0]  ADDR_CHAN0     = 4'h0;
  localparam logic [3:0]  ADDR_CHAN1     = 4'h1;

  localparam logic [9:0]  WIPER_MIDSCALE = 10'h200;
  localparam logic [15:0] NV_WIPER_RESET = 16'h0200;
  localparam logic [15:0] NV_USER_RESET  = 16'h0000;

  localparam int          CLK_PERIOD_PS  = 25000;
  localparam int          NV_WRITE_NS    = 200;
  localparam int          NV_WRITE_CYCLES = (NV_WRITE_NS * 1000 + CLK_PERIOD_PS - 1) /
                                            CLK_PERIOD_PS;
  localparam logic [3:0]  NV_WRITE_COUNT = 4'(NV_WRITE_CYCLES);

  localparam int          PIN_SCLK       = 0;
  localparam int          PIN_CS         = 1;
  localparam int          PIN_DATA_IN    = 2;
  localparam int          PIN_WP         = 3;
  localparam int          PIN_PRESET     = 4;
  localparam logic [4:0]  SYNC_IDLE      = 5'h0a;

  typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_APPLY, ST_WRITE, ST_DONE} rscp_state_t;

endpackage
`default_nettype wire

/* File: hw/rscp_nv_store.sv */
`timescale 1ns/1ps
`default_nettype none
module rscp_nv_store import rscp_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  rd_addr,
  output logic      [15:0] rd_data,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_addr,
  input  wire logic [15:0] wr_data
);

  typedef struct packed {
    logic [NV_DEPTH-1:0][NV_BITS-1:0] mem;
    logic [NV_BITS-1:0]               rd_data;
  } rscp_nv_t;

  // Flops stand in for the cells; reset plays the factory image
  localparam rscp_nv_t NV_RESET = '{mem: {{(NV_DEPTH-2){NV_USER_RESET}},
                                          NV_WIPER_RESET, NV_WIPER_RESET},
                                    rd_data: '0};

  rscp_nv_t q;
  rscp_nv_t d;

  always_comb begin
    d = q;
    if (wr_en) begin
      d.mem[wr_addr] = wr_data;
    end
    d.rd_data = q.mem[rd_addr];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= NV_RESET;
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rd_data;

endmodule
`default_nettype wire

/* File: hw/rscp_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Capture one bit per serial clock rise while select is low
// - Word arrives MSB first, sampled rising
// - Data out echoes input 24 clocks late
// - Commands 9, 10 shift register data out
// - Address 0 picks channel 0, 1 channel 1
// - Write protect blocks all store changes
// - Reloads from store still run when protected
// - Preset copies store into both wipers
// - Preset acts on its rising edge only
// - Store entries 0, 1 default to midscale 512, the rest to 0
// - Execute only when select rises
// - Ready marks end of 2,3,8,9,10, preset
// - Word is command, address, sixteen data
// - Codes 0, 1, 8: nop, load, reload
// - Next full word carries readback data
module rscp_top import rscp_pkg::*; (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       serial_clk,
  input  wire logic       chip_select_n,
  input  wire logic       serial_data_in,
  input  wire logic       write_protect_n,
  input  wire logic       hardware_preset,
  input  wire logic       serial_data_out_in,
  output logic            serial_data_out_o,
  output logic            serial_data_out_oe,
  input  wire logic       ready_in,
  output logic            ready_o,
  output logic            ready_oe,
  output logic      [9:0] wiper_register_0,
  output logic      [9:0] wiper_register_1
);

  typedef struct packed {
    logic [4:0]                      sync1;
    logic [4:0]                      sync2;
    logic [4:0]                      sync3;
    rscp_state_t                     state;
    logic [WORD_BITS-1:0]            shift;
    logic [1:0][WIPER_BITS-1:0]      wiper;
    logic [3:0]                      op_cmd;
    logic [3:0]                      op_addr;
    logic                            op_second;
    logic [3:0]                      wait_cnt;
    logic                            ready;
  } rscp_regs_t;

  localparam rscp_regs_t REGS_RESET = '{sync1: SYNC_IDLE, sync2: SYNC_IDLE, sync3: SYNC_IDLE,
                                        state: ST_IDLE, shift: '0,
                                        wiper: {WIPER_MIDSCALE, WIPER_MIDSCALE},
                                        op_cmd: CMD_NOP, op_addr: ADDR_CHAN0,
                                        op_second: 1'b0, wait_cnt: '0, ready: 1'b1};

  logic [1:0]         rst_sync;
  logic               rst_n;
  rscp_regs_t         q;
  rscp_regs_t         d;
  logic               sclk_rise;
  logic               cs_low;
  logic               cs_rise;
  logic               preset_rise;
  logic               wp_on;
  logic [3:0]         cmd;
  logic [3:0]         addr;
  logic [15:0]        data;
  logic               nv_we;
  logic [3:0]         nv_wa;
  logic [15:0]        nv_wd;
  logic [15:0]        nv_rd;

  // Commands that change the store, or a wiper other than by reload from the store
  function automatic logic guarded(input logic [3:0] c);
    return !(c inside {CMD_NOP, CMD_NV_TO_WIPER, CMD_RELOAD_ALL, CMD_READ_NV, CMD_READ_WIPER});
  endfunction

  function automatic logic completes(input logic [3:0] c);
    return c inside {CMD_SAVE_WIPER, CMD_WRITE_NV, CMD_RELOAD_ALL, CMD_READ_NV, CMD_READ_WIPER};
  endfunction

  function automatic logic [9:0] wiper_op(input logic [3:0] c, input logic [9:0] w,
                                          input logic [9:0] v);
    logic [9:0] r;
    r = w;
    case (c)
      CMD_RSHIFT, CMD_RSHIFT_ALL: r = w >> 1;
      CMD_DEC, CMD_DEC_ALL:       r = (w == '0) ? w : w - 10'h001;
      CMD_LSHIFT, CMD_LSHIFT_ALL: r = w[9] ? '1 : {w[8:0], 1'b0};
      CMD_INC, CMD_INC_ALL:       r = (&w) ? w : w + 10'h001;
      CMD_WRITE_WIPER:            r = v;
      default:                    r = w;
    endcase
    return r;
  endfunction

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign sclk_rise   = q.sync2[PIN_SCLK] & ~q.sync3[PIN_SCLK];
  assign cs_low      = ~q.sync2[PIN_CS];
  assign cs_rise     = q.sync2[PIN_CS] & ~q.sync3[PIN_CS];
  assign preset_rise = q.sync2[PIN_PRESET] & ~q.sync3[PIN_PRESET];
  assign wp_on       = ~q.sync2[PIN_WP];
  assign cmd         = q.shift[WORD_BITS-1:CMD_LSB];
  assign addr        = q.shift[CMD_LSB-1:ADDR_LSB];
  assign data        = q.shift[ADDR_LSB-1:0];

  always_comb begin
    d       = q;
    nv_we   = 1'b0;
    nv_wa   = q.op_addr;
    nv_wd   = '0;
    d.sync1 = {hardware_preset, write_protect_n, serial_data_in, chip_select_n, serial_clk};
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    if (sclk_rise && cs_low) begin
      d.shift = {q.shift[WORD_BITS-2:0], q.sync2[PIN_DATA_IN]};
    end
    unique case (q.state)
      ST_IDLE: begin
        if (preset_rise) begin
          d.op_cmd    = CMD_RELOAD_ALL;
          d.op_addr   = ADDR_CHAN0;
          d.op_second = 1'b0;
          d.ready     = 1'b0;
          d.state     = ST_READ;
        end else if (cs_rise && !(wp_on && guarded(cmd))) begin
          d.op_cmd    = cmd;
          d.op_addr   = {3'h0, addr[0]};
          d.op_second = 1'b0;
          if (completes(cmd)) begin
            d.ready = 1'b0;
          end
          unique case (cmd)
            CMD_NOP: begin
            end
            CMD_NV_TO_WIPER: d.state = ST_READ;
            CMD_READ_NV: begin
              d.op_addr = addr;
              d.state   = ST_READ;
            end
            CMD_RELOAD_ALL: begin
              d.op_addr = ADDR_CHAN0;
              d.state   = ST_READ;
            end
            CMD_SAVE_WIPER, CMD_WRITE_NV: begin
              nv_we      = 1'b1;
              nv_wa      = (cmd == CMD_WRITE_NV) ? addr : {3'h0, addr[0]};
              nv_wd      = (cmd == CMD_WRITE_NV) ? data : {6'h00, q.wiper[addr[0]]};
              d.wait_cnt = NV_WRITE_COUNT;
              d.state    = ST_WRITE;
            end
            CMD_READ_WIPER: begin
              d.shift[15:0] = {6'h00, q.wiper[addr[0]]};
              d.state       = ST_DONE;
            end
            default: begin
              for (int i = 0; i < 2; i++) begin
                if (cmd[0] && cmd != CMD_WRITE_WIPER || addr[0] == 1'(i)) begin
                  d.wiper[i] = wiper_op(cmd, q.wiper[i], data[WIPER_BITS-1:0]);
                end
              end
            end
          endcase
        end
      end
      ST_READ: d.state = ST_APPLY;
      ST_APPLY: begin
        if (q.op_cmd == CMD_READ_NV) begin
          d.shift[15:0] = nv_rd;
        end else begin
          d.wiper[q.op_addr[0]] = nv_rd[WIPER_BITS-1:0];
        end
        if (q.op_cmd == CMD_RELOAD_ALL && !q.op_second) begin
          d.op_second = 1'b1;
          d.op_addr   = ADDR_CHAN1;
          d.state     = ST_READ;
        end else begin
          d.state = ST_DONE;
        end
      end
      ST_WRITE: begin
        d.wait_cnt = q.wait_cnt - 4'h1;
        if (q.wait_cnt == 4'h1) begin
          d.state = ST_DONE;
        end
      end
      ST_DONE: begin
        d.ready = 1'b1;
        d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= REGS_RESET;
    end else begin
      q <= d;
    end
  end

  rscp_nv_store u_store (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .rd_addr  (q.op_addr),
    .rd_data  (nv_rd),
    .wr_en    (nv_we),
    .wr_addr  (nv_wa),
    .wr_data  (nv_wd)
  );

  // Open drain: only ever pull low; MSB of the shifter is the echo
  assign serial_data_out_o  = 1'b0;
  assign serial_data_out_oe = ~q.shift[WORD_BITS-1];
  assign ready_o            = 1'b0;
  assign ready_oe           = ~q.ready;
  assign wiper_register_0   = q.wiper[0];
  assign wiper_register_1   = q.wiper[1];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic [5:0] busy_cnt;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= '0;
    end else begin
      busy_cnt <= q.ready ? 6'h00 : busy_cnt + 6'h01;
    end
  end

  sequence s_reload_two;
    q.state == ST_READ ##1 q.state == ST_APPLY ##1 q.state == ST_READ ##1 q.state == ST_APPLY;
  endsequence

  a_shift_capture: assert property (sclk_rise && cs_low && q.state != ST_APPLY |=>
    q.shift == {$past(q.shift[WORD_BITS-2:0]), $past(q.sync2[PIN_DATA_IN])})
    else $error("serial bit not captured");
  a_deselect_hold: assert property (!cs_low && !cs_rise && q.state != ST_APPLY |=>
    $stable(q.shift))
    else $error("shift register moved while deselected");
  a_echo_delay: assert property (sclk_rise && cs_low && q.state != ST_APPLY |=>
    serial_data_out_oe == !$past(q.shift[WORD_BITS-2]))
    else $error("data out not echoing shifted word");
  a_readback_load: assert property (q.state == ST_APPLY && q.op_cmd == CMD_READ_NV |=>
    q.shift[15:0] == $past(nv_rd))
    else $error("readback data not loaded");
  a_apply_load: assert property (q.state == ST_APPLY && q.op_cmd != CMD_READ_NV |=>
    q.wiper[$past(q.op_addr[0])] == $past(nv_rd[WIPER_BITS-1:0]))
    else $error("wiper not reloaded from store");
  a_protect_block: assert property (q.state == ST_IDLE && cs_rise && wp_on &&
    !preset_rise && guarded(cmd) |-> !nv_we ##1 ($stable(q.wiper) && q.state == ST_IDLE))
    else $error("protected write changed a wiper");
  a_preset_reload: assert property (q.state == ST_IDLE && preset_rise |=> s_reload_two)
    else $error("preset did not reload both wipers");
  a_ready_drop: assert property (q.state == ST_IDLE && !preset_rise && cs_rise &&
    completes(cmd) && !(wp_on && guarded(cmd)) |=> !q.ready)
    else $error("ready not released at start");
  a_ready_return: assert property ($fell(q.ready) |-> ##[1:20] q.ready)
    else $error("ready did not return");
  a_busy_bound: assert property (busy_cnt <= 6'h14)
    else $error("operation ran too long");
  a_chan_select: assert property (q.state == ST_IDLE && !preset_rise && cs_rise &&
    cmd == CMD_WRITE_WIPER && !wp_on |=> q.wiper[$past(addr[0])] == $past(data[9:0]))
    else $error("wiper write went to wrong channel");

endmodule
`default_nettype wire

/* File: verif/rscp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rscp_host_model (
  input  wire logic core_clk,
  input  wire logic data_out_line,
  output logic      serial_clk,
  output logic      chip_select_n,
  output logic      serial_data_in
);
  initial begin
    serial_clk     = 1'b0;
    chip_select_n  = 1'b1;
    serial_data_in = 1'b0;
  end

  // Whole word under one select low, MSB first, 200 ns serial period
  task automatic send_word(input logic [23:0] word, output logic [23:0] rx);
    @(posedge core_clk);
    chip_select_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      serial_data_in <= word[i];
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      rx[i] = data_out_line;
      @(posedge core_clk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
      serial_clk <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    chip_select_n  <= 1'b1;
    // Released line shows the inverse so no stale bit looks valid
    serial_data_in <= ~word[0];
  endtask

  // Activity while deselected, clock ends low when n is even
  task automatic idle_toggle(input int n);
    repeat (n) begin
      @(posedge core_clk);
      serial_clk     <= ~serial_clk;
      serial_data_in <= ~serial_data_in;
      repeat (3) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/rheostat_serial_control_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module rheostat_serial_control_port_tb import rscp_pkg::*; ;
  logic        core_clk;
  logic        resetn;
  logic        write_protect_n;
  logic        hardware_preset;
  wire logic   serial_clk;
  wire logic   chip_select_n;
  wire logic   serial_data_in;
  wire logic   data_out_o;
  wire logic   data_out_oe;
  wire logic   ready_o;
  wire logic   ready_oe;
  wire logic   data_out_line;
  wire logic   ready_line;
  wire logic [9:0] wiper0;
  wire logic [9:0] wiper1;
  int          failures = 0;
  int          checked = 0;
  logic [23:0] rx;

  // Both open-drain lines have pull-ups
  assign data_out_line = data_out_oe ? data_out_o : 1'b1;
  assign ready_line    = ready_oe ? ready_o : 1'b1;

  rscp_top dut (.core_clk(core_clk), .resetn(resetn), .serial_clk(serial_clk),
    .chip_select_n(chip_select_n), .serial_data_in(serial_data_in),
    .write_protect_n(write_protect_n), .hardware_preset(hardware_preset),
    .serial_data_out_in(data_out_line), .serial_data_out_o(data_out_o),
    .serial_data_out_oe(data_out_oe),
    .ready_in(ready_line), .ready_o(ready_o), .ready_oe(ready_oe),
    .wiper_register_0(wiper0), .wiper_register_1(wiper1));

  rscp_host_model host (.core_clk(core_clk), .data_out_line(data_out_line),
    .serial_clk(serial_clk),
    .chip_select_n(chip_select_n), .serial_data_in(serial_data_in));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic busy_check(input int exp_busy);
    int busy;
    busy = 0;
    repeat (24) begin
      @(negedge core_clk);
      if (ready_line !== 1'b1) busy++;
    end
    `CHK("ready busy cycles", exp_busy, busy)
  endtask

  task automatic exec(input logic [23:0] word, input int exp_busy);
    host.send_word(word, rx);
    busy_check(exp_busy);
  endtask

  task automatic t_reset_vals();
    `CHK("wiper0 reset", WIPER_MIDSCALE, wiper0)
    `CHK("wiper1 reset", WIPER_MIDSCALE, wiper1)
  endtask

  task automatic t_write_echo();
    exec({CMD_WRITE_WIPER, ADDR_CHAN0, 16'h0155}, 0);
    `CHK("wiper0 write", 10'h155, wiper0)
    `CHK("wiper1 kept", WIPER_MIDSCALE, wiper1)
    exec({CMD_WRITE_WIPER, ADDR_CHAN1, 16'h02aa}, 0);
    `CHK("echo word", {CMD_WRITE_WIPER, ADDR_CHAN0, 16'h0155}, rx)
    `CHK("wiper1 write", 10'h2aa, wiper1)
    host.idle_toggle(6);
    exec({CMD_NOP, 4'h0, 16'h0000}, 0);
    `CHK("echo after idle", {CMD_WRITE_WIPER, ADDR_CHAN1, 16'h02aa}, rx)
  endtask

  task automatic t_readback();
    exec({CMD_READ_WIPER, ADDR_CHAN1, 16'h0000}, 1);
    exec({CMD_NOP, 4'h0, 16'h0000}, 0);
    `CHK("wiper readback", {CMD_READ_WIPER, ADDR_CHAN1, 6'h00, 10'h2aa}, rx)
    exec({CMD_SAVE_WIPER, ADDR_CHAN1, 16'h0000}, 9);
    exec({CMD_READ_NV, ADDR_CHAN1, 16'h0000}, 3);
    exec({CMD_NOP, 4'h0, 16'h0000}, 0);
    `CHK("store readback", {CMD_READ_NV, ADDR_CHAN1, 16'h02aa}, rx)
  endtask

  task automatic t_reload();
    exec({CMD_WRITE_NV, 4'h0, 16'h0123}, 9);
    exec({CMD_RELOAD_ALL, 4'h0, 16'h0000}, 5);
    `CHK("wiper0 reload", 10'h123, wiper0)
    `CHK("wiper1 reload", 10'h2aa, wiper1)
  endtask

  task automatic t_protect();
    exec({CMD_WRITE_WIPER, ADDR_CHAN0, 16'h0155}, 0);
    @(posedge core_clk);
    write_protect_n <= 1'b0;
    exec({CMD_WRITE_WIPER, ADDR_CHAN0, 16'h03ff}, 0);
    `CHK("protected wiper", 10'h155, wiper0)
    exec({CMD_WRITE_NV, 4'h0, 16'h0001}, 0);
    exec({CMD_RELOAD_ALL, 4'h0, 16'h0000}, 5);
    `CHK("protected reload", 10'h123, wiper0)
    exec({CMD_NOP, 4'h0, 16'h0000}, 0);
    @(posedge core_clk);
    write_protect_n <= 1'b1;
  endtask

  task automatic t_preset();
    exec({CMD_WRITE_WIPER, ADDR_CHAN0, 16'h0001}, 0);
    @(posedge core_clk);
    hardware_preset <= 1'b1;
    busy_check(5);
    `CHK("preset wiper0", 10'h123, wiper0)
    `CHK("preset wiper1", 10'h2aa, wiper1)
    exec({CMD_WRITE_WIPER, ADDR_CHAN0, 16'h0002}, 0);
    `CHK("preset level", 10'h002, wiper0)
    @(posedge core_clk);
    hardware_preset <= 1'b0;
  endtask

  // Every wiper arithmetic code, saturation at both ends, then a protected pair
  task automatic t_wiper_ops();
    exec({CMD_INC, ADDR_CHAN0, 16'h0000}, 0);
    `CHK("wiper0 inc", 10'h003, wiper0)
    exec({CMD_DEC_ALL, 4'h0, 16'h0000}, 0);
    `CHK("wiper0 dec all", 10'h002, wiper0)
    `CHK("wiper1 dec all", 10'h2a9, wiper1)
    exec({CMD_LSHIFT, ADDR_CHAN1, 16'h0000}, 0);
    `CHK("wiper1 left sat", 10'h3ff, wiper1)
    `CHK("wiper0 left kept", 10'h002, wiper0)
    exec({CMD_INC_ALL, 4'h0, 16'h0000}, 0);
    `CHK("wiper0 inc all", 10'h003, wiper0)
    `CHK("wiper1 inc sat", 10'h3ff, wiper1)
    exec({CMD_RSHIFT_ALL, 4'h0, 16'h0000}, 0);
    `CHK("wiper0 right all", 10'h001, wiper0)
    `CHK("wiper1 right all", 10'h1ff, wiper1)
    exec({CMD_LSHIFT_ALL, 4'h0, 16'h0000}, 0);
    `CHK("wiper0 left all", 10'h002, wiper0)
    `CHK("wiper1 left all", 10'h3fe, wiper1)
    exec({CMD_RSHIFT, ADDR_CHAN0, 16'h0000}, 0);
    `CHK("wiper0 right", 10'h001, wiper0)
    exec({CMD_DEC, ADDR_CHAN0, 16'h0000}, 0);
    exec({CMD_DEC, ADDR_CHAN0, 16'h0000}, 0);
    `CHK("wiper0 dec sat", 10'h000, wiper0)
    `CHK("wiper1 dec kept", 10'h3fe, wiper1)
    @(posedge core_clk);
    write_protect_n <= 1'b0;
    exec({CMD_INC, ADDR_CHAN1, 16'h0000}, 0);
    `CHK("protected inc", 10'h3fe, wiper1)
    exec({CMD_NV_TO_WIPER, ADDR_CHAN1, 16'h0000}, 0);
    `CHK("protected load", 10'h2aa, wiper1)
    `CHK("load other kept", 10'h000, wiper0)
    exec({CMD_NOP, 4'h0, 16'h0000}, 0);
    @(posedge core_clk);
    write_protect_n <= 1'b1;
  endtask

  // Guard against a hang anywhere in the sequence
  initial begin
    repeat (40000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end

  initial begin
    resetn          = 1'b0;
    write_protect_n = 1'b1;
    hardware_preset = 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge core_clk);
    t_reset_vals();
    t_write_echo();
    t_readback();
    t_reload();
    t_protect();
    t_preset();
    t_wiper_ops();
    report_and_stop();
  end
endmodule
`default_nettype wire
